// ===== src/srpm_consts.svh
// Operation
// R1: Controller issues one auto refresh command per refresh; none repeat alone.
// R2: Controller precharges all open banks before any auto refresh.
// R3: Controller should wait the precharge period after precharge before refreshing.
// R4: Auto refresh row comes from the internal counter; address and bank ignored.
// R5: Controller sends only NOP or inhibit until refresh cycle time elapses.
// R6: Controller refreshes every row each refresh period, spread or in bursts.
// R7: Refresh encoding with clock enable low enters self refresh; inputs ignored.
// R8: Self refresh uses internal timing and refreshes rows without external clock.
// R9: Controller keeps self refresh for at least the row active time.
// R10: Exit needs stable clock, clock enable high, then NOPs for exit time.
// R11: After self refresh, controller resumes distributed auto refresh; counter shared.
// R12: Clock enable low with NOP and no access enters precharge or active power-down.
// R13: Power-down switches off all input and output buffers except clock enable.
// R14: Controller keeps power-down shorter than the refresh period.
// R15: NOP or inhibit registered with clock enable high ends power-down.
// R16: Idle banks, deep power-down encoding and clock enable low enter deep power-down.
// R17: Deep power-down removes array power; stored contents are lost.
// R18: Controller exits deep power-down with clock enable high, then full initialization.
// R19: Clock enable low during a burst suspends the next internal clock edge.
// R20: Suspended edge ignores commands and write data, holds output data and burst.
// R21: Clock enable registered high resumes internal clocking on the next edge.
// R22: Controller times refresh interval, refresh cycle and exit with its own counters.
`ifndef SRPM_CONSTS_SVH
`define SRPM_CONSTS_SVH

// ----------------------------------------
// Command encodings {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------
`define SRPM_CMD_REFRESH 4'h1
`define SRPM_CMD_DEEP_PD 4'h6
`define SRPM_CMD_NOP 4'h7
`define SRPM_CMD_INHIBIT 4'hF

// ----------------------------------------
// Timing
// ----------------------------------------
`define SRPM_CLK_PERIOD_PS 5000
`define SRPM_REFRESH_PERIOD_NS 64000000
`define SRPM_REFRESH_ROWS 8192
`define SRPM_SELF_REF_CYC \
  ((`SRPM_REFRESH_PERIOD_NS / `SRPM_REFRESH_ROWS) * 1000 / `SRPM_CLK_PERIOD_PS)

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define SRPM_ROW_W 13
`define SRPM_OSC_W 11
`define SRPM_ROW_RST 13'h0000
`define SRPM_OSC_RST 11'h000
`define SRPM_BANKS 4
`define SRPM_CKE_RST 1'b1
`define SRPM_SR_CNT_W 12
`define SRPM_SR_CNT_RST 12'h000
`define SRPM_SR_CNT_MAX 12'hFA0

`endif

// ===== src/srpm_pkg.sv
package srpm_pkg;

  typedef enum logic [2:0] {
    SRPM_NORMAL,
    SRPM_SELF_REF,
    SRPM_PWR_DOWN,
    SRPM_DEEP_PD,
    SRPM_SUSPEND
  } srpm_state_t;

  // Command pins as sampled at the clock edge
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } srpm_cmd_t;

  // Power state flags reported to the core
  typedef struct packed {
    logic self_ref;
    logic pwr_down;
    logic active_pd;
    logic deep_pd;
    logic suspend;
  } srpm_status_t;

endpackage

// ===== src/srpm_osc.sv
`timescale 1ns/1ps
`include "srpm_consts.svh"

module srpm_osc
  import srpm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  output logic tick
);

  // ----------------------------------------
  // Internal refresh timer
  // ----------------------------------------
  localparam logic [`SRPM_OSC_W-1:0] LAST =
    `SRPM_OSC_W'(`SRPM_SELF_REF_CYC - 1);

  logic [`SRPM_OSC_W-1:0] cnt_q;
  logic [`SRPM_OSC_W-1:0] cnt_d;
  logic tick_q;
  logic tick_d;

  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (!run) begin
      cnt_d = `SRPM_OSC_RST;
    end else if (cnt_q == LAST) begin
      cnt_d = `SRPM_OSC_RST;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + `SRPM_OSC_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= `SRPM_OSC_RST;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule

// ===== src/srpm_top.sv
`timescale 1ns/1ps
`include "srpm_consts.svh"

module srpm_top
  import srpm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cke_pin,
  input wire srpm_cmd_t cmd_pin,
  input wire logic [`SRPM_BANKS-1:0] bank_open,
  input wire logic burst_active,
  output srpm_cmd_t cmd_out,
  output logic cmd_valid,
  output logic refresh_req,
  output logic [`SRPM_ROW_W-1:0] refresh_row,
  output logic int_clk_en,
  output logic dq_hold,
  output logic buf_en,
  output logic array_pwr_en,
  output logic init_req,
  output srpm_status_t status
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic cke_m_q;
  logic cke_s_q;
  srpm_cmd_t cmd_m_q;
  srpm_cmd_t cmd_s_q;

  // Pins are asynchronous to this clock; first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // Idle levels, so a release never looks like a power-down entry
      cke_m_q <= `SRPM_CKE_RST;
      cke_s_q <= `SRPM_CKE_RST;
      cmd_m_q <= srpm_cmd_t'(`SRPM_CMD_INHIBIT);
      cmd_s_q <= srpm_cmd_t'(`SRPM_CMD_INHIBIT);
    end else begin
      cke_m_q <= cke_pin;
      cke_s_q <= cke_m_q;
      cmd_m_q <= cmd_pin;
      cmd_s_q <= cmd_m_q;
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  logic is_inhibit;
  logic is_nop;
  logic is_refresh;
  logic is_deep_pd;
  logic is_idle_cmd;
  logic all_idle;

  assign is_inhibit = cmd_s_q.cs_n;
  assign is_nop = (cmd_s_q == `SRPM_CMD_NOP);
  assign is_refresh = (cmd_s_q == `SRPM_CMD_REFRESH);
  assign is_deep_pd = (cmd_s_q == `SRPM_CMD_DEEP_PD);
  assign is_idle_cmd = is_inhibit || is_nop;
  assign all_idle = (bank_open == '0);

  // ----------------------------------------
  // Self refresh timer
  // ----------------------------------------
  srpm_state_t state_q;
  srpm_state_t state_d;
  logic osc_tick;

  srpm_osc u_osc (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(state_q == SRPM_SELF_REF),
    .tick(osc_tick)
  );

  // ----------------------------------------
  // Power state machine
  // ----------------------------------------
  logic act_pd_q;
  logic act_pd_d;
  logic susp_q;
  logic susp_d;
  logic init_q;
  logic init_d;
  logic ref_q;
  logic ref_d;
  logic [`SRPM_ROW_W-1:0] row_q;
  logic [`SRPM_ROW_W-1:0] row_d;
  logic [`SRPM_ROW_W-1:0] ref_row_q;
  logic [`SRPM_ROW_W-1:0] ref_row_d;
  srpm_cmd_t cmd_out_q;
  srpm_cmd_t cmd_out_d;
  logic cmd_v_q;
  logic cmd_v_d;
  logic buf_q;
  logic buf_d;
  logic arr_q;
  logic arr_d;
  logic [`SRPM_SR_CNT_W-1:0] sr_cnt_q;
  logic [`SRPM_SR_CNT_W-1:0] sr_cnt_d;

  always_comb begin
    state_d = state_q;
    act_pd_d = act_pd_q;
    susp_d = 1'b0;
    init_d = init_q;
    ref_d = 1'b0;
    row_d = row_q;
    ref_row_d = ref_row_q;
    cmd_out_d = cmd_out_q;
    cmd_v_d = 1'b0;
    buf_d = buf_q;
    arr_d = arr_q;
    case (state_q)
      SRPM_NORMAL, SRPM_SUSPEND: begin
        if (!cke_s_q && burst_active) begin
          // Next internal edge is skipped while the burst stays frozen
          state_d = SRPM_SUSPEND; // [R19]
          susp_d = 1'b1; // [R19]
        end else if (state_q == SRPM_SUSPEND) begin
          // Last suspended edge: command and write data dropped
          state_d = SRPM_NORMAL; // [R21]
          cmd_v_d = 1'b0; // [R20]
        end else if (!cke_s_q && is_refresh && all_idle) begin
          state_d = SRPM_SELF_REF; // [R7]
          buf_d = 1'b0;
        end else if (!cke_s_q && is_deep_pd && all_idle) begin
          state_d = SRPM_DEEP_PD; // [R16]
          buf_d = 1'b0;
          arr_d = 1'b0; // [R17]
        end else if (!cke_s_q && is_idle_cmd) begin
          state_d = SRPM_PWR_DOWN; // [R12]
          act_pd_d = !all_idle; // [R12]
          buf_d = 1'b0; // [R13]
        end else if (cke_s_q && is_refresh) begin
          // Bank and address are don't care here
          ref_d = 1'b1; // [R4]
          ref_row_d = row_q; // [R4]
          row_d = row_q + `SRPM_ROW_W'(1); // [R4]
        end else if (cke_s_q && !is_idle_cmd) begin
          cmd_out_d = cmd_s_q;
          cmd_v_d = 1'b1;
        end
      end
      SRPM_SELF_REF: begin
        // Only clock enable is watched; all other pins ignored
        if (cke_s_q) begin
          state_d = SRPM_NORMAL; // [R7]
          buf_d = 1'b1;
        end else if (osc_tick) begin
          // Shared row counter keeps advancing on internal timing
          ref_d = 1'b1; // [R8]
          ref_row_d = row_q; // [R8]
          row_d = row_q + `SRPM_ROW_W'(1); // [R8]
        end
      end
      SRPM_PWR_DOWN: begin
        if (cke_s_q && is_idle_cmd) begin
          state_d = SRPM_NORMAL; // [R15]
          act_pd_d = 1'b0;
          buf_d = 1'b1; // [R15]
        end
      end
      SRPM_DEEP_PD: begin
        if (cke_s_q) begin
          // Array contents gone; core must be reinitialised
          state_d = SRPM_NORMAL; // [R17]
          init_d = 1'b1; // [R17]
          buf_d = 1'b1;
          arr_d = 1'b1;
        end
      end
      default: begin
        state_d = SRPM_NORMAL;
      end
    endcase
    // Initialization sequence clears the flag on first executable command
    if (cmd_v_d) begin
      init_d = 1'b0;
    end
    // Saturating dwell count in self refresh
    if (state_q != SRPM_SELF_REF) begin
      sr_cnt_d = `SRPM_SR_CNT_RST;
    end else if (sr_cnt_q != `SRPM_SR_CNT_MAX) begin
      sr_cnt_d = sr_cnt_q + `SRPM_SR_CNT_W'(1);
    end else begin
      sr_cnt_d = sr_cnt_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= SRPM_NORMAL;
      act_pd_q <= 1'b0;
      susp_q <= 1'b0;
      init_q <= 1'b0;
      ref_q <= 1'b0;
      row_q <= `SRPM_ROW_RST;
      ref_row_q <= `SRPM_ROW_RST;
      cmd_out_q <= srpm_cmd_t'(`SRPM_CMD_INHIBIT);
      cmd_v_q <= 1'b0;
      buf_q <= 1'b1;
      arr_q <= 1'b1;
      sr_cnt_q <= `SRPM_SR_CNT_RST;
    end else begin
      state_q <= state_d;
      act_pd_q <= act_pd_d;
      susp_q <= susp_d;
      init_q <= init_d;
      ref_q <= ref_d;
      row_q <= row_d;
      ref_row_q <= ref_row_d;
      cmd_out_q <= cmd_out_d;
      cmd_v_q <= cmd_v_d;
      buf_q <= buf_d;
      arr_q <= arr_d;
      sr_cnt_q <= sr_cnt_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cmd_out = cmd_out_q;
  assign cmd_valid = cmd_v_q;
  assign refresh_req = ref_q;
  assign refresh_row = ref_row_q;
  assign int_clk_en = !susp_q; // [R19]
  assign dq_hold = susp_q; // [R20]
  assign buf_en = buf_q;
  assign array_pwr_en = arr_q;
  assign init_req = init_q;
  assign status.self_ref = (state_q == SRPM_SELF_REF);
  assign status.pwr_down = (state_q == SRPM_PWR_DOWN);
  assign status.active_pd = act_pd_q;
  assign status.deep_pd = (state_q == SRPM_DEEP_PD);
  assign status.suspend = susp_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  logic in_normal;
  assign in_normal = (state_q == SRPM_NORMAL) && !susp_q;

  property p_ar_row;
    (in_normal && cke_s_q && is_refresh && !burst_active)
      |=> refresh_req && (refresh_row == $past(row_q))
          && (row_q == $past(row_q) + `SRPM_ROW_W'(1));
  endproperty
  a_ar_row: assert property (p_ar_row) // [R4]
    else $error("Auto refresh did not use internal row");

  property p_sr_enter;
    (in_normal && !cke_s_q && is_refresh && all_idle && !burst_active)
      |=> status.self_ref && !buf_en;
  endproperty
  a_sr_enter: assert property (p_sr_enter) // [R7]
    else $error("Self refresh not entered");

  property p_sr_hold;
    (status.self_ref && !cke_s_q) |=> status.self_ref && !cmd_valid;
  endproperty
  a_sr_hold: assert property (p_sr_hold) // [R7]
    else $error("Self refresh left while clock enable low");

  property p_sr_tick;
    (status.self_ref && !cke_s_q && osc_tick)
      |=> refresh_req && (refresh_row == $past(row_q));
  endproperty
  a_sr_tick: assert property (p_sr_tick) // [R8]
    else $error("Internal refresh missed");

  property p_pd_enter;
    (in_normal && !cke_s_q && is_idle_cmd && !burst_active)
      |=> status.pwr_down && (status.active_pd == $past(!all_idle));
  endproperty
  a_pd_enter: assert property (p_pd_enter) // [R12]
    else $error("Power-down entry wrong");

  property p_pd_buf;
    status.pwr_down |-> !buf_en && !cmd_valid;
  endproperty
  a_pd_buf: assert property (p_pd_buf) // [R13]
    else $error("Buffers on in power-down");

  property p_pd_exit;
    (status.pwr_down && cke_s_q && is_idle_cmd)
      |=> (state_q == SRPM_NORMAL) && buf_en && !status.active_pd;
  endproperty
  a_pd_exit: assert property (p_pd_exit) // [R15]
    else $error("Power-down exit missed");

  property p_dpd_enter;
    (in_normal && !cke_s_q && is_deep_pd && all_idle && !burst_active)
      |=> status.deep_pd ##0 !array_pwr_en;
  endproperty
  a_dpd_enter: assert property (p_dpd_enter) // [R16]
    else $error("Deep power-down not entered");

  property p_dpd_exit;
    (status.deep_pd && cke_s_q) |=> array_pwr_en && init_req;
  endproperty
  a_dpd_exit: assert property (p_dpd_exit) // [R17]
    else $error("Deep power-down exit lacks init request");

  property p_susp;
    ((state_q == SRPM_NORMAL || state_q == SRPM_SUSPEND)
      && !cke_s_q && burst_active)
      |=> !int_clk_en && dq_hold && !cmd_valid;
  endproperty
  a_susp: assert property (p_susp) // [R19]
    else $error("Internal edge not suspended");

  property p_susp_freeze;
    !int_clk_en |-> dq_hold && !refresh_req && $stable(row_q);
  endproperty
  a_susp_freeze: assert property (p_susp_freeze) // [R20]
    else $error("Suspended edge not frozen");

  property p_resume;
    (state_q == SRPM_SUSPEND && cke_s_q) |=> int_clk_en;
  endproperty
  a_resume: assert property (p_resume) // [R21]
    else $error("Clock suspend not released");

  c_self_ref: cover property (status.self_ref && refresh_req
    && (sr_cnt_q != `SRPM_SR_CNT_MAX));
  c_pd: cover property (status.pwr_down ##1 state_q == SRPM_NORMAL);
  c_dpd: cover property (status.deep_pd ##[1:20] init_req);
  c_susp: cover property (!int_clk_en [*3] ##1 int_clk_en);

endmodule

// ===== verif/srpm_ctrl_model.sv
`timescale 1ns/1ps
`include "srpm_consts.svh"

module srpm_ctrl_model
  import srpm_pkg::*;
#(
  parameter int PRECHARGE_CYC = 2,
  parameter int REFRESH_CYC = 4
)
(
  input wire logic clk_sys,
  output srpm_cmd_t cmd_pin,
  output logic cke_pin,
  output logic [`SRPM_BANKS-1:0] bank_open,
  output logic burst_active
);
  // ----
  // Pins change just after a falling edge
  // ----
  initial begin
    cke_pin = 1'b1;
    cmd_pin = `SRPM_CMD_NOP;
    bank_open = 4'h0;
    burst_active = 1'b0;
  end

  task automatic drive(input logic cke, input logic [3:0] cmd);
    @(negedge clk_sys);
    cke_pin = cke;
    cmd_pin = cmd;
  endtask

  // Core side stand-in for open rows and bursts
  task automatic set_core(input logic [3:0] banks, input logic burst);
    @(negedge clk_sys);
    bank_open = banks;
    burst_active = burst;
  endtask

  // Counted waits stand in for the controller timers
  task automatic nops(input int n);
    repeat (n) drive(cke_pin, `SRPM_CMD_NOP);
  endtask

  // ----
  // One refresh; caller sets the pace
  // ----
  task automatic refresh();
    set_core(4'h0, 1'b0);
    nops(PRECHARGE_CYC);
    drive(1'b1, `SRPM_CMD_REFRESH);
    nops(REFRESH_CYC);
  endtask
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`include "srpm_consts.svh"

`define CHK(a, e) begin \
  compares++; \
  if ((a) !== (e)) begin \
    n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); \
  end \
end

module tb_top;
  import srpm_pkg::*;

  // ----
  // Wiring
  // ----
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cke_pin;
  srpm_cmd_t cmd_pin;
  logic [`SRPM_BANKS-1:0] bank_open;
  logic burst_active;
  srpm_cmd_t cmd_out;
  logic cmd_valid;
  logic refresh_req;
  logic [`SRPM_ROW_W-1:0] refresh_row;
  logic int_clk_en;
  logic dq_hold;
  logic buf_en;
  logic array_pwr_en;
  logic init_req;
  srpm_status_t status;
  int n_mismatch = 0;
  int compares = 0;
  int exp_row = 0;
  int n_ref = 0;
  logic [3:0] exp_q[$];

  always #2.5 clk_sys = ~clk_sys;

  srpm_ctrl_model i_ctrl (
    .clk_sys(clk_sys),
    .cmd_pin(cmd_pin),
    .cke_pin(cke_pin),
    .bank_open(bank_open),
    .burst_active(burst_active)
  );

  srpm_top i_dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .cke_pin(cke_pin),
    .cmd_pin(cmd_pin),
    .bank_open(bank_open),
    .burst_active(burst_active),
    .cmd_out(cmd_out),
    .cmd_valid(cmd_valid),
    .refresh_req(refresh_req),
    .refresh_row(refresh_row),
    .int_clk_en(int_clk_en),
    .dq_hold(dq_hold),
    .buf_en(buf_en),
    .array_pwr_en(array_pwr_en),
    .init_req(init_req),
    .status(status)
  );

  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Command then NOP; returns where the result has landed
  task automatic fire(input logic cke, input logic [3:0] cmd);
    i_ctrl.drive(cke, cmd);
    i_ctrl.drive(cke, `SRPM_CMD_NOP);
    settle(2);
  endtask

  // ----
  // Reference model: row counter and command queue
  // ----
  always @(negedge clk_sys) begin
    logic [3:0] e;
    if (!rst) begin
      `CHK(dq_hold, ~int_clk_en)
      if (refresh_req) begin
        `CHK(refresh_row, 13'(exp_row))
        exp_row++;
        n_ref++;
      end
      if (cmd_valid) begin
        if (exp_q.size() == 0) begin
          `CHK(cmd_valid, 1'b0)
        end else begin
          e = exp_q.pop_front();
          `CHK(cmd_out, e)
        end
      end
    end
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    logic [3:0] c;
    logic [3:0] b;
    int t0;
    int seen;
    void'($urandom(32'h0000_c70f));
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    settle(3);
    `CHK({int_clk_en, dq_hold, buf_en, array_pwr_en, init_req}, 5'h16)
    // Back-to-back commands with inhibits mixed in
    i_ctrl.set_core(4'($urandom), 1'b0);
    repeat (24) begin
      c = 4'($urandom);
      if (c == `SRPM_CMD_REFRESH) c = 4'h3;
      if (!c[3] && c != `SRPM_CMD_NOP) exp_q.push_back(c);
      i_ctrl.drive(1'b1, c);
    end
    i_ctrl.nops(4);
    `CHK(exp_q.size(), 0)
    repeat (3) i_ctrl.refresh();
    `CHK(n_ref, 3)
    // Self refresh with noise on the command pins
    fire(1'b0, `SRPM_CMD_REFRESH);
    `CHK(status, 5'h10)
    `CHK(buf_en, 1'b0)
    seen = 0;
    t0 = 0;
    for (int i = 0; i < 3300 && seen < 2; i++) begin
      i_ctrl.drive(1'b0, 4'($urandom));
      if (refresh_req) begin
        if (seen == 1) `CHK(i - t0, `SRPM_SELF_REF_CYC)
        seen++;
        t0 = i;
      end
    end
    if (seen < 2) begin
      n_mismatch++;
      report_and_stop();
    end
    fire(1'b1, `SRPM_CMD_NOP);
    `CHK({status, buf_en}, 6'h01)
    i_ctrl.nops(6);
    i_ctrl.refresh();
    // Precharge then active power-down
    for (int k = 0; k < 2; k++) begin
      b = k ? (4'($urandom) | 4'h1) : 4'h0;
      i_ctrl.set_core(b, 1'b0);
      fire(1'b0, `SRPM_CMD_NOP);
      `CHK(status, {1'b0, 1'b1, |b, 2'h0})
      `CHK(buf_en, 1'b0)
      i_ctrl.drive(1'b0, 4'h3);
      fire(1'b1, `SRPM_CMD_NOP);
      `CHK({status, buf_en}, 6'h01)
    end
    // Deep power-down, exit flags the need for init
    i_ctrl.set_core(4'h0, 1'b0);
    fire(1'b0, `SRPM_CMD_DEEP_PD);
    `CHK(status, 5'h02)
    `CHK(array_pwr_en, 1'b0)
    i_ctrl.nops(5);
    fire(1'b1, `SRPM_CMD_NOP);
    `CHK({array_pwr_en, init_req}, 2'h3)
    exp_q.push_back(4'h3);
    fire(1'b1, 4'h3);
    settle(1);
    `CHK(init_req, 1'b0)
    // Clock suspend inside a burst
    i_ctrl.set_core(4'h1, 1'b1);
    i_ctrl.drive(1'b0, `SRPM_CMD_NOP);
    settle(3);
    `CHK({int_clk_en, dq_hold, status}, 7'h21)
    i_ctrl.drive(1'b0, 4'h4);
    i_ctrl.drive(1'b1, `SRPM_CMD_NOP);
    settle(3);
    `CHK({int_clk_en, status}, 6'h20)
    settle(1);
    `CHK(int_clk_en, 1'b1)
    i_ctrl.set_core(4'h0, 1'b0);
    i_ctrl.nops(4);
    `CHK(exp_q.size(), 0)
    report_and_stop();
  end
endmodule
